/* rtl/hpcc_pkg.sv */
// Purpose: constants shared by the hot-plug configuration control block
// Assumes: apb with 32-bit data, one register word per offset
// Notes: field positions, reset values and the register offsets live here
package hpcc_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int HPCC_PORTS = 6;
	localparam int HPCC_AW = 12;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] HPCC_OFF_CFG = 12'h408;
	localparam logic [11:0] HPCC_OFF_STAT = 12'h40C;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int HPCC_B_INV_BUTTON = 0;
	localparam int HPCC_B_INV_PRESENCE = 1;
	localparam int HPCC_B_INV_FAULT = 2;
	localparam int HPCC_B_INV_LATCH = 3;
	localparam int HPCC_B_INV_ATTN_IND = 4;
	localparam int HPCC_B_INV_PWR_IND = 5;
	localparam int HPCC_B_INV_PWR_EN = 6;
	localparam int HPCC_B_INV_LOCK = 7;
	localparam int HPCC_B_INV_PGOOD = 8;
	localparam int HPCC_B_MODE_LO = 9;
	localparam int HPCC_B_LATCH_OFF = 11;
	localparam int HPCC_CFG_BITS = 12;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [11:0] HPCC_CFG_RESET = 12'h800;
	localparam logic [31:0] HPCC_ZERO_WORD = 32'h00000000;

	// ----------------------------------------
	// presence report modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		HPCC_PRES_BOTH = 2'h0,
		HPCC_PRES_SIGNAL = 2'h1,
		HPCC_PRES_ALWAYS = 2'h2,
		HPCC_PRES_NEVER = 2'h3
	} hpcc_pres_mode_t;

endpackage : hpcc_pkg

/* rtl/hpcc_sync.sv */
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module hpcc_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// ----------------------------------------
	// two stage capture
	// ----------------------------------------
	// stage one is read by stage two only, to contain metastability
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : hpcc_sync

/* rtl/hpcc_port.sv */
// Purpose: per-port pin polarity, presence report and latch power-off
// Assumes: inputs are already synchronised; config from the register
// Notes: one instance per downstream port
`timescale 1ns/1ps
module hpcc_port
	import hpcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [HPCC_CFG_BITS-1:0] cfg,
	input wire logic latch_present_capability,
	input wire logic power_controller_control,
	input wire logic receiver_detect,
	input wire logic btn_raw,
	input wire logic pres_raw,
	input wire logic fault_raw,
	input wire logic latch_raw,
	input wire logic pgood_raw,
	input wire logic attn_ind_on,
	input wire logic pwr_ind_on,
	input wire logic lock_on,
	output logic button_pressed,
	output logic presence_reported,
	output logic power_fault,
	output logic latch_open,
	output logic power_good,
	output logic slot_power_on,
	output logic attention_indicator_output,
	output logic power_indicator_output,
	output logic slot_power_enable_output,
	output logic interlock_output
);
	logic pres_in;
	logic latch_in;
	logic pres_d;
	logic latch_kill_q;
	hpcc_pres_mode_t mode;

	// ----------------------------------------
	// input sense
	// ----------------------------------------
	// pins are active low; an invert bit makes them active high
	assign button_pressed = ~(btn_raw ^ cfg[HPCC_B_INV_BUTTON]); // [R1]
	assign pres_in = ~(pres_raw ^ cfg[HPCC_B_INV_PRESENCE]); // [R2]
	assign power_fault = ~(fault_raw ^ cfg[HPCC_B_INV_FAULT]); // [R3]
	assign latch_in = ~(latch_raw ^ cfg[HPCC_B_INV_LATCH]); // [R4]
	assign power_good = ~(pgood_raw ^ cfg[HPCC_B_INV_PGOOD]); // [R9]
	assign latch_open = latch_in;
	assign mode = hpcc_pres_mode_t'(cfg[HPCC_B_MODE_LO +: 2]);

	// ----------------------------------------
	// presence report selection
	// ----------------------------------------
	always_comb begin
		case (mode)
			HPCC_PRES_BOTH: pres_d = receiver_detect | pres_in; // [R10]
			HPCC_PRES_SIGNAL: pres_d = pres_in; // [R11]
			HPCC_PRES_ALWAYS: pres_d = 1'b1; // [R12]
			HPCC_PRES_NEVER: pres_d = 1'b0; // [R12]
			default: pres_d = 1'b0;
		endcase
	end

	// registered so the report does not glitch on mode writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presence_reported <= 1'b0;
		end else begin
			presence_reported <= pres_d;
		end
	end

	// ----------------------------------------
	// latch-open power removal
	// ----------------------------------------
	// overrides the power controller bit whatever its value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_kill_q <= 1'b0;
		end else begin
			latch_kill_q <= cfg[HPCC_B_LATCH_OFF] & latch_present_capability & latch_in; // [R13]
		end
	end

	// power controller control is 0 for power on
	assign slot_power_on = ~power_controller_control & ~latch_kill_q; // [R14]

	// ----------------------------------------
	// output polarity, active high pins by default
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attention_indicator_output <= 1'b0;
			power_indicator_output <= 1'b0;
			slot_power_enable_output <= 1'b0;
			interlock_output <= 1'b0;
		end else begin
			attention_indicator_output <= attn_ind_on ^ cfg[HPCC_B_INV_ATTN_IND]; // [R5]
			power_indicator_output <= pwr_ind_on ^ cfg[HPCC_B_INV_PWR_IND]; // [R6]
			slot_power_enable_output <= slot_power_on ^ cfg[HPCC_B_INV_PWR_EN]; // [R7]
			interlock_output <= lock_on ^ cfg[HPCC_B_INV_LOCK]; // [R8]
		end
	end
endmodule : hpcc_port

/* rtl/hpcc_top.sv */
// Purpose: hot-plug configuration control register with apb access
// Assumes: presetn is the fundamental reset; hot_reset_n is non-fundamental
// Notes: register fields are sticky; pins pass two flops before use
`timescale 1ns/1ps
// Functional notes
// [R1] bit 0 inverts attention button input sense on all ports
// [R2] bit 1 inverts presence detect input sense on all ports
// [R3] bit 2 inverts power fault input sense on all ports
// [R4] bit 3 inverts latch sensor input sense on all ports
// [R5] bit 4 inverts attention indicator output on all ports
// [R6] bit 5 inverts power indicator output on all ports
// [R7] bit 6 inverts slot power enable output on all ports
// [R8] bit 7 inverts interlock output on all ports
// [R9] bit 8 inverts power good input sense on all ports
// [R10] mode 0 reports presence as receiver detect or presence input
// [R11] mode 1 reports presence from presence input only
// [R12] mode 2 always present, mode 3 never present
// [R13] bit 11 with latch capability turns slot power off on latch open
// [R14] latch power-off overrides the power controller control bit
// [R15] all fields sticky; only fundamental reset restores defaults
module hpcc_top
	import hpcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hot_reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [HPCC_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic latch_present_capability,
	input wire logic [HPCC_PORTS-1:0] power_controller_control,
	input wire logic [HPCC_PORTS-1:0] receiver_detect_select,
	input wire logic [HPCC_PORTS-1:0] attn_ind_on,
	input wire logic [HPCC_PORTS-1:0] pwr_ind_on,
	input wire logic [HPCC_PORTS-1:0] lock_on,
	input wire logic [HPCC_PORTS-1:0] attention_button_input,
	input wire logic [HPCC_PORTS-1:0] presence_detect_input,
	input wire logic [HPCC_PORTS-1:0] power_fault_input,
	input wire logic [HPCC_PORTS-1:0] latch_sensor_input,
	input wire logic [HPCC_PORTS-1:0] power_good_input,
	output logic [HPCC_PORTS-1:0] button_pressed,
	output logic [HPCC_PORTS-1:0] presence_reported,
	output logic [HPCC_PORTS-1:0] power_fault,
	output logic [HPCC_PORTS-1:0] latch_open,
	output logic [HPCC_PORTS-1:0] power_good,
	output logic [HPCC_PORTS-1:0] attention_indicator_output,
	output logic [HPCC_PORTS-1:0] power_indicator_output,
	output logic [HPCC_PORTS-1:0] slot_power_enable_output,
	output logic [HPCC_PORTS-1:0] interlock_output
);
	localparam int NP = HPCC_PORTS;

	logic [HPCC_CFG_BITS-1:0] cfg_q;
	logic [NP-1:0] rdet_s;
	logic [NP-1:0] btn_s;
	logic [NP-1:0] pres_s;
	logic [NP-1:0] fault_s;
	logic [NP-1:0] latch_s;
	logic [NP-1:0] pgood_s;
	logic [NP-1:0] power_on;
	logic [HPCC_CFG_BITS-1:0] wr_d;
	logic access;
	logic hit_cfg;
	logic hit_stat;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// grouped into one bus so all pins share one synchroniser instance
	hpcc_sync #(.W(6 * NP)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({receiver_detect_select, attention_button_input, presence_detect_input,
			power_fault_input, latch_sensor_input, power_good_input}),
		.dout({rdet_s, btn_s, pres_s, fault_s, latch_s, pgood_s})
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	// zero wait state slave; pready is always high
	assign pready = 1'b1;
	assign access = psel & penable;
	assign hit_cfg = (paddr == HPCC_OFF_CFG);
	assign hit_stat = (paddr == HPCC_OFF_STAT);
	// unmapped addresses and writes to the status word return an error
	assign pslverr = access & ~(hit_cfg | (hit_stat & ~pwrite));

	// byte lane merge for the two low bytes
	always_comb begin
		wr_d = cfg_q;
		if (pstrb[0]) begin
			wr_d[7:0] = pwdata[7:0];
		end
		if (pstrb[1]) begin
			wr_d[HPCC_CFG_BITS-1:8] = pwdata[HPCC_CFG_BITS-1:8];
		end
	end

	// ----------------------------------------
	// configuration register
	// ----------------------------------------
	// hot_reset_n is deliberately not in the reset list: fields survive it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= HPCC_CFG_RESET; // [R15]
		end else if (access & pwrite & hit_cfg) begin
			cfg_q <= wr_d;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// status word: current power state per port, then presence per port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= HPCC_ZERO_WORD;
		end else if (psel & ~penable & ~pwrite) begin
			if (paddr == HPCC_OFF_CFG) begin
				prdata <= {20'h00000, cfg_q};
			end else if (paddr == HPCC_OFF_STAT) begin
				prdata <= {20'h00000, presence_reported, power_on};
			end else begin
				prdata <= HPCC_ZERO_WORD;
			end
		end
	end

	// ----------------------------------------
	// per-port logic
	// ----------------------------------------
	for (genvar i = 0; i < NP; i++) begin : g_port
		hpcc_port u_port (
			.pclk(pclk),
			.presetn(presetn),
			.cfg(cfg_q),
			.latch_present_capability(latch_present_capability),
			.power_controller_control(power_controller_control[i]),
			.receiver_detect(rdet_s[i]),
			.btn_raw(btn_s[i]),
			.pres_raw(pres_s[i]),
			.fault_raw(fault_s[i]),
			.latch_raw(latch_s[i]),
			.pgood_raw(pgood_s[i]),
			.attn_ind_on(attn_ind_on[i]),
			.pwr_ind_on(pwr_ind_on[i]),
			.lock_on(lock_on[i]),
			.button_pressed(button_pressed[i]),
			.presence_reported(presence_reported[i]),
			.power_fault(power_fault[i]),
			.latch_open(latch_open[i]),
			.power_good(power_good[i]),
			.slot_power_on(power_on[i]),
			.attention_indicator_output(attention_indicator_output[i]),
			.power_indicator_output(power_indicator_output[i]),
			.slot_power_enable_output(slot_power_enable_output[i]),
			.interlock_output(interlock_output[i])
		);
	end
endmodule : hpcc_top

/* testbench/hpcc_properties.sv */
// Purpose: port-level checks for the hot-plug configuration block
// Assumes: pins pass two flops before use; apb answers at once
// Notes: shadows the config word from observed apb writes
`timescale 1ns/1ps
module hpcc_properties
	import hpcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [HPCC_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic latch_present_capability,
	input wire logic [HPCC_PORTS-1:0] receiver_detect_select,
	input wire logic [HPCC_PORTS-1:0] attn_ind_on,
	input wire logic [HPCC_PORTS-1:0] attention_button_input,
	input wire logic [HPCC_PORTS-1:0] presence_detect_input,
	input wire logic [HPCC_PORTS-1:0] latch_sensor_input,
	input wire logic [HPCC_PORTS-1:0] button_pressed,
	input wire logic [HPCC_PORTS-1:0] presence_reported,
	input wire logic [HPCC_PORTS-1:0] latch_open,
	input wire logic [HPCC_PORTS-1:0] attention_indicator_output,
	input wire logic [HPCC_PORTS-1:0] slot_power_enable_output
);
	// ----
	// helper logic
	// ----
	logic [11:0] cfg_q;
	logic [1:0] up_q;
	logic [5:0] bs1_q, bs2_q, ls1_q, ls2_q, ps1_q, ps2_q, rs1_q, rs2_q, k1_q, k2_q, pres_exp;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// shadow config; up_q hides the synchroniser fill after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= HPCC_CFG_RESET;
			up_q <= 2'h0;
		end else begin
			if (psel && penable && pwrite && paddr == HPCC_OFF_CFG && pstrb[0]) cfg_q[7:0] <= pwdata[7:0];
			if (psel && penable && pwrite && paddr == HPCC_OFF_CFG && pstrb[1]) cfg_q[11:8] <= pwdata[11:8];
			if (up_q != 2'h3) up_q <= up_q + 2'h1;
		end
	end
	// two-stage pin pipes and latch kill history
	always_ff @(posedge pclk) begin
		{bs2_q, bs1_q} <= {bs1_q, attention_button_input};
		{ls2_q, ls1_q} <= {ls1_q, latch_sensor_input};
		{ps2_q, ps1_q} <= {ps1_q, presence_detect_input};
		{rs2_q, rs1_q} <= {rs1_q, receiver_detect_select};
		{k2_q, k1_q} <= {k1_q, latch_open & {6{latch_present_capability & cfg_q[11]}}};
	end
	// expected presence per report mode
	always_comb begin
		case (cfg_q[10:9])
			2'h0: pres_exp = rs2_q | ~(ps2_q ^ {6{cfg_q[1]}});
			2'h1: pres_exp = ~(ps2_q ^ {6{cfg_q[1]}});
			2'h2: pres_exp = 6'h3F;
			default: pres_exp = 6'h00;
		endcase
	end
	// ----
	// assertions
	// ----
	a_button_sense: assert property (
		up_q == 2'h3 |-> button_pressed == ~(bs2_q ^ {6{cfg_q[0]}})) else $error("button sense wrong");
	a_latch_sense: assert property (
		up_q == 2'h3 |-> latch_open == ~(ls2_q ^ {6{cfg_q[3]}})) else $error("latch sense wrong");
	a_attn_out_pol: assert property (
		up_q == 2'h3 |-> attention_indicator_output == ($past(attn_ind_on) ^ {6{$past(cfg_q[4])}}))
		else $error("attention output wrong");
	a_presence_mode: assert property (
		up_q == 2'h3 |-> presence_reported == $past(pres_exp)) else $error("presence report wrong");
	a_latch_kill: assert property (
		up_q == 2'h3 && (k1_q & k2_q) != 6'h00
		|-> ((slot_power_enable_output ^ {6{$past(cfg_q[6])}}) & k1_q & k2_q) == 6'h00)
		else $error("slot power not removed");
	a_cfg_readback: assert property (
		psel && penable && !pwrite && paddr == HPCC_OFF_CFG |-> prdata == {20'h00000, cfg_q} && !pslverr)
		else $error("config readback wrong");
	a_unmapped_err: assert property (
		psel && penable && paddr != HPCC_OFF_CFG && paddr != HPCC_OFF_STAT |-> pslverr)
		else $error("unmapped access not refused");
	a_status_ro: assert property (
		psel && penable && pwrite && paddr == HPCC_OFF_STAT |-> pslverr) else $error("status write accepted");
	c_cfg_write: cover property (psel && penable && pwrite && paddr == HPCC_OFF_CFG);
	c_kill: cover property ((k1_q & k2_q) != 6'h00);
	c_never: cover property (cfg_q[10:9] == 2'h3);
endmodule : hpcc_properties

bind hpcc_top hpcc_properties u_hpcc_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pslverr, .latch_present_capability, .receiver_detect_select, .attn_ind_on,
	.attention_button_input, .presence_detect_input, .latch_sensor_input, .button_pressed,
	.presence_reported, .latch_open, .attention_indicator_output, .slot_power_enable_output);

/* testbench/hpcc_slot_model.sv */
// Purpose: board side of the slots: sensors and power switches
// Assumes: sensors pull their pin low when asserted
// Notes: power good follows the enable one cycle late
`timescale 1ns/1ps
module hpcc_slot_model (
	input wire logic pclk,
	input wire logic [5:0] btn_req,
	input wire logic [5:0] pres_req,
	input wire logic [5:0] fault_req,
	input wire logic [5:0] latch_req,
	input wire logic [5:0] slot_power_enable_output,
	output logic [5:0] attention_button_input,
	output logic [5:0] presence_detect_input,
	output logic [5:0] power_fault_input,
	output logic [5:0] latch_sensor_input,
	output logic [5:0] power_good_input
);
	// active-low sensor pins
	assign attention_button_input = ~btn_req;
	assign presence_detect_input = ~pres_req;
	assign power_fault_input = ~fault_req;
	assign latch_sensor_input = ~latch_req;
	// switch needs a cycle to settle, so good lags enable
	always_ff @(posedge pclk) begin
		power_good_input <= ~slot_power_enable_output;
	end
endmodule : hpcc_slot_model

/* testbench/hotplug_config_control_tb.sv */
// Purpose: directed bench for the hot-plug configuration block
// Assumes: apb master waits on pready; pins come from the slot model
// Notes: one idle cycle between transfers
`timescale 1ns/1ps
module hotplug_config_control_tb
	import hpcc_pkg::*;
();
	logic pclk = 1'b0, presetn = 1'b0, hot_reset_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rdat;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, rerr, latch_present_capability = 1'b0;
	logic [5:0] power_controller_control = 6'h00, receiver_detect_select = 6'h00, attn_ind_on = 6'h00;
	logic [5:0] pwr_ind_on = 6'h00, lock_on = 6'h00, btn_req = 6'h00, pres_req = 6'h00, fault_req = 6'h00;
	logic [5:0] latch_req = 6'h00, attention_button_input, presence_detect_input, power_fault_input;
	logic [5:0] latch_sensor_input, power_good_input, button_pressed, presence_reported, power_fault;
	logic [5:0] latch_open, power_good, attention_indicator_output, power_indicator_output;
	logic [5:0] slot_power_enable_output, interlock_output;
	logic [11:0] sc [5] = '{12'h000, 12'h001, 12'h004, 12'h008, 12'h100};
	logic [23:0] se [5] = '{24'hFFFFFF, 24'h03FFFF, 24'hFC0FFF, 24'hFFF03F, 24'hFFFFC0};
	logic [11:0] oc [5] = '{12'h000, 12'h010, 12'h020, 12'h040, 12'h080};
	logic [23:0] oe [5] = '{24'h56AFCF, 24'hAAAFCF, 24'h555FCF, 24'h56A00F, 24'h56AFF0};
	logic [11:0] pc [5] = '{12'h000, 12'h200, 12'h400, 12'h600, 12'h202};
	logic [5:0] pe [5] = '{6'h0E, 6'h0C, 6'h3F, 6'h00, 6'h33};
	int n_fail = 0;
	int cmp_count = 0;
	hpcc_top u_hpcc_top (.*);
	hpcc_slot_model u_hpcc_slot_model (.*);
	// ----
	// tasks
	// ----
	// waits on pready as long as it takes; only the watchdog ends a hung transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// ----
	// clock, watchdog, tests
	// ----
	initial begin
		forever #10 pclk = ~pclk;
	end
	// whole run is about 150 cycles; generous margin
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, HPCC_OFF_CFG, 32'h0, 4'hF);
		chk(rdat, 32'h00000800);
		btn_req <= 6'h3F;
		fault_req <= 6'h3F;
		latch_req <= 6'h3F;
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, HPCC_OFF_CFG, {20'h0, sc[k]}, 4'hF);
			repeat (4) @(posedge pclk);
			chk({8'h0, button_pressed, power_fault, latch_open, power_good}, {8'h0, se[k]});
		end
		attn_ind_on <= 6'h15;
		pwr_ind_on <= 6'h2A;
		lock_on <= 6'h0F;
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, HPCC_OFF_CFG, {20'h0, oc[k]}, 4'hF);
			repeat (3) @(posedge pclk);
			chk({8'h0, attention_indicator_output, power_indicator_output, slot_power_enable_output,
				interlock_output}, {8'h0, oe[k]});
		end
		pres_req <= 6'h0C;
		receiver_detect_select <= 6'h0A;
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, HPCC_OFF_CFG, {20'h0, pc[k]}, 4'hF);
			repeat (4) @(posedge pclk);
			chk({26'h0, presence_reported}, {26'h0, pe[k]});
		end
		// latch closed, one port switched off by control
		latch_req <= 6'h00;
		latch_present_capability <= 1'b1;
		power_controller_control <= 6'h01;
		apb(1'b1, HPCC_OFF_CFG, 32'h800, 4'hF);
		repeat (6) @(posedge pclk);
		chk({26'h0, slot_power_enable_output}, 32'h3E);
		latch_req <= 6'h05;
		repeat (6) @(posedge pclk);
		chk({26'h0, slot_power_enable_output}, 32'h3A);
		// status word: presence 0E in bits 11:6, power on 3A in bits 5:0
		apb(1'b0, HPCC_OFF_STAT, 32'h0, 4'hF);
		chk(rdat, 32'h000003BA);
		latch_present_capability <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({26'h0, slot_power_enable_output}, 32'h3E);
		// sticky across hot reset, byte strobes, refusals
		apb(1'b1, HPCC_OFF_CFG, 32'h5A5, 4'hF);
		hot_reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		hot_reset_n <= 1'b1;
		apb(1'b1, HPCC_OFF_CFG, 32'hFFFFFFFF, 4'h1);
		apb(1'b0, HPCC_OFF_CFG, 32'h0, 4'hF);
		chk(rdat, 32'h000005FF);
		apb(1'b0, 12'h000, 32'h0, 4'hF);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		apb(1'b1, HPCC_OFF_STAT, 32'hFFF, 4'hF);
		chk({31'h0, rerr}, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, HPCC_OFF_CFG, 32'h0, 4'hF);
		chk(rdat, 32'h00000800);
		final_report();
	end
endmodule : hotplug_config_control_tb
